// [hdl/pccs_pkg.sv]
// shared constants and types for the cipher counter block
package pccs_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int CNT_W = 48;                // full cipher counter
  localparam int LT_W  = 32;                // mpcp local time
  localparam int EXT_W = 16;                // upper extension
  localparam int TAG_W = 6;                 // header position tag
  localparam int ROWS  = 2 ** TAG_W;        // receive buffer rows

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [LT_W-1:0]  LT_RST  = 32'h0000_0000;
  localparam logic [EXT_W-1:0] EXT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RST = 48'h0000_0000_0000;

  // ****************************************************************
  // sync sequencer states
  // ****************************************************************
  typedef enum logic [0:0] {
    SYNC_IDLE,
    SYNC_ADJ
  } pccs_sync_t;

endpackage

// [hdl/pccs_top.sv]
// cipher clock counters, position tag alignment and one-time sync
//
// How it works
// - cipher counters are distinct 48-bit, stepping with mpcp
// - terminal uses one counter for both paths
// - network unit holds transmit and receive counters
// - mpcp local time: 32 bits, +1 per quantum
// - terminal counter: 16-bit extension, carry into bit 32
// - unit transmit counter built the same way
// - unit receive counter is separate, steps with time
// - sent header tag = local time low 6 bits
// - terminal reads row when local time[5:0] matches
// - unit reads row when receive counter[5:0] matches
// - latch counter on tx write and rx read
// - unit steps both stamps until tx[31:0]=time
// - unit loads stamps, then counters follow local time
// - unit may check receive alignment
// - terminal may share one 48-bit register
// - unit may derive receive from transmit minus rtt
// - iv_time_field = counter captured at start header
// - captured counter low 6 bits equal the tag
`timescale 1ns/10ps

module pccs_top #(
  parameter bit IS_UNIT = 1'b0,             // 1: network unit, 0: line terminal
  parameter int HDR_W   = 32                // stored envelope_header width
) (
  // clock and reset
  input  wire logic                       core_clk_in,
  input  wire logic                       srst_in,
  // mpcp time base
  input  wire logic                       eqt_tick_in,
  input  wire logic                       mpcp_load_in,
  input  wire logic [pccs_pkg::LT_W-1:0]  mpcp_load_val_in,
  // transmit path: header written into envelope_transmit_buffer
  input  wire logic                       tx_hdr_in,
  // receive path: header written into envelope_receive_buffer
  input  wire logic                       rx_hdr_in,
  input  wire logic [pccs_pkg::TAG_W-1:0] rx_tag_in,
  input  wire logic [HDR_W-1:0]           rx_hdr_data_in,
  // counter_sync_tlv stamps (network unit only)
  input  wire logic                       sync_req_in,
  input  wire logic [pccs_pkg::CNT_W-1:0] transmit_sync_stamp_in,
  input  wire logic [pccs_pkg::CNT_W-1:0] receive_sync_stamp_in,
  // counters
  output logic      [pccs_pkg::LT_W-1:0]  mpcp_local_time_out,
  output logic      [pccs_pkg::CNT_W-1:0] tx_cipher_count_out,
  output logic      [pccs_pkg::CNT_W-1:0] rx_cipher_count_out,
  // transmit capture
  output logic                            tx_valid_out,
  output logic      [pccs_pkg::TAG_W-1:0] tx_tag_out,
  output logic      [pccs_pkg::CNT_W-1:0] tx_time_out,
  // receive read-out and capture
  output logic                            rx_valid_out,
  output logic      [pccs_pkg::TAG_W-1:0] rx_row_out,
  output logic      [HDR_W-1:0]           rx_hdr_data_out,
  output logic      [pccs_pkg::CNT_W-1:0] rx_time_out,
  // sync status
  output logic                            sync_busy_out,
  output logic                            sync_done_out,
  output logic                            rx_align_err_out
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [pccs_pkg::LT_W-1:0]             lt;
    logic [pccs_pkg::EXT_W-1:0]            ext;
    logic [pccs_pkg::CNT_W-1:0]            rxc;
    logic [pccs_pkg::CNT_W-1:0]            txs;
    logic [pccs_pkg::CNT_W-1:0]            rxs;
    pccs_pkg::pccs_sync_t                  sst;
    logic                                  busy;
    logic                                  done;
    logic                                  tx_vld;
    logic [pccs_pkg::TAG_W-1:0]            tx_tag;
    logic [pccs_pkg::CNT_W-1:0]            tx_time;
    logic                                  rx_vld;
    logic [pccs_pkg::TAG_W-1:0]            rx_row;
    logic [HDR_W-1:0]                      rx_data;
    logic [pccs_pkg::CNT_W-1:0]            rx_time;
    logic                                  rx_err;
    logic [pccs_pkg::ROWS-1:0]             row_vld;
    logic [pccs_pkg::ROWS-1:0][HDR_W-1:0]  row_data;
  } pccs_state_t;

  pccs_state_t                  st_r;
  pccs_state_t                  st_nxt;
  logic [pccs_pkg::CNT_W-1:0]   tx_cnt;   // terminal counter / unit transmit counter
  logic [pccs_pkg::CNT_W-1:0]   rx_cnt;   // counter that paces the receive buffer
  logic [pccs_pkg::TAG_W-1:0]   rd_row;
  logic [pccs_pkg::CNT_W-1:0]   step;
  logic [pccs_pkg::CNT_W-1:0]   inc;
  logic [pccs_pkg::CNT_W-1:0]   txs_ld;
  logic [pccs_pkg::CNT_W-1:0]   rxs_ld;
  logic                         rd_hit;

  // ****************************************************************
  // counter views
  // ****************************************************************
  // the 48-bit transmit view is the extension over local time, so the
  // carry out of local time lands in bit 32 through the extension's own increment
  assign tx_cnt = {st_r.ext, st_r.lt};
  // terminal paces both paths from one counter, unit from its own
  assign rx_cnt = IS_UNIT ? st_r.rxc : tx_cnt;
  assign rd_row = rx_cnt[pccs_pkg::TAG_W-1:0];
  assign rd_hit = eqt_tick_in & st_r.row_vld[rd_row];

  // sync stepping: two per cycle when local time also ticks, so the
  // gap closes by one on each cycle without an mpcp load and can never be overshot
  always_comb begin
    step    = '0;
    inc     = '0;
    step[0] = ~eqt_tick_in;
    step[1] = eqt_tick_in;
    inc[0]  = eqt_tick_in;
  end

  // loaded value already includes a tick that lands in the load cycle
  assign txs_ld = st_r.txs + inc;
  assign rxs_ld = st_r.rxs + inc;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_nxt        = st_r;
    st_nxt.done   = 1'b0;
    st_nxt.tx_vld = 1'b0;
    st_nxt.rx_vld = 1'b0;

    // local time and extension; a discovery load overrides the step
    if (mpcp_load_in) begin
      st_nxt.lt = mpcp_load_val_in;
    end else if (eqt_tick_in) begin
      st_nxt.lt = st_r.lt + 1'b1;
      if (&st_r.lt) begin
        st_nxt.ext = st_r.ext + 1'b1;
      end
    end

    // receive counter steps with time but keeps its own origin
    if (eqt_tick_in) begin
      st_nxt.rxc = st_r.rxc + 1'b1;
    end

    // one-time sync of the upper bits, network unit only
    unique case (st_r.sst)
      pccs_pkg::SYNC_IDLE: begin
        if (IS_UNIT && sync_req_in) begin
          st_nxt.txs  = transmit_sync_stamp_in;
          st_nxt.rxs  = receive_sync_stamp_in;
          st_nxt.sst  = pccs_pkg::SYNC_ADJ;
          st_nxt.busy = 1'b1;
        end
      end
      pccs_pkg::SYNC_ADJ: begin
        if (st_r.txs[pccs_pkg::LT_W-1:0] == st_r.lt) begin
          // both counters take their stamps in the same cycle
          st_nxt.ext  = txs_ld[pccs_pkg::CNT_W-1:pccs_pkg::LT_W];
          st_nxt.rxc  = rxs_ld;
          st_nxt.sst  = pccs_pkg::SYNC_IDLE;
          st_nxt.busy = 1'b0;
          st_nxt.done = 1'b1;
        end else begin
          st_nxt.txs = st_r.txs + step;
          st_nxt.rxs = st_r.rxs + step;
        end
      end
    endcase

    // transmit capture at header write
    if (tx_hdr_in) begin
      st_nxt.tx_vld  = 1'b1;
      st_nxt.tx_tag  = st_r.lt[pccs_pkg::TAG_W-1:0];
      st_nxt.tx_time = tx_cnt;
    end

    // receive read-out: the row whose index matches the pacing
    // counter leaves on the tick, with that counter captured
    if (rd_hit) begin
      st_nxt.rx_vld          = 1'b1;
      st_nxt.rx_row          = rd_row;
      st_nxt.rx_data         = st_r.row_data[rd_row];
      st_nxt.rx_time         = rx_cnt;
      st_nxt.row_vld[rd_row] = 1'b0;
    end

    // a new sync clears the alignment flag; a fresh error still wins
    if (IS_UNIT && st_r.sst == pccs_pkg::SYNC_IDLE && sync_req_in) begin
      st_nxt.rx_err = 1'b0;
    end

    // receive write; overwriting an unread row means misalignment
    if (rx_hdr_in) begin
      if (st_r.row_vld[rx_tag_in] && !(rd_hit && rd_row == rx_tag_in)) begin
        st_nxt.rx_err = 1'b1;
      end
      st_nxt.row_vld[rx_tag_in]  = 1'b1;
      st_nxt.row_data[rx_tag_in] = rx_hdr_data_in;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // buffer contents are cleared too, trading area for a known start
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st_r     <= '0;
      st_r.lt  <= pccs_pkg::LT_RST;
      st_r.ext <= pccs_pkg::EXT_RST;
      st_r.rxc <= pccs_pkg::CNT_RST;
      st_r.sst <= pccs_pkg::SYNC_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // all taken straight from flops
  assign mpcp_local_time_out = st_r.lt;
  assign tx_cipher_count_out = tx_cnt;
  assign rx_cipher_count_out = rx_cnt;
  assign tx_valid_out        = st_r.tx_vld;
  assign tx_tag_out          = st_r.tx_tag;
  assign tx_time_out         = st_r.tx_time;
  assign rx_valid_out        = st_r.rx_vld;
  assign rx_row_out          = st_r.rx_row;
  assign rx_hdr_data_out     = st_r.rx_data;
  assign rx_time_out         = st_r.rx_time;
  assign sync_busy_out       = st_r.busy;
  assign sync_done_out       = st_r.done;
  assign rx_align_err_out    = st_r.rx_err;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  property p_lt_step;
    eqt_tick_in && !mpcp_load_in |=> st_r.lt == $past(st_r.lt) + 1'b1;
  endproperty
  a_lt_step: assert property (p_lt_step) else $error("local time did not step");

  property p_carry;
    eqt_tick_in && !mpcp_load_in && (&st_r.lt) && st_r.sst == pccs_pkg::SYNC_IDLE
      |=> st_r.ext == $past(st_r.ext) + 1'b1 && st_r.lt == '0;
  endproperty
  a_carry: assert property (p_carry) else $error("carry missed bit 32");

  property p_tag;
    tx_hdr_in |=> tx_valid_out && tx_tag_out == $past(st_r.lt[pccs_pkg::TAG_W-1:0]);
  endproperty
  a_tag: assert property (p_tag) else $error("position tag wrong");

  property p_tx_latch;
    tx_hdr_in |=> tx_time_out == $past(tx_cnt);
  endproperty
  a_tx_latch: assert property (p_tx_latch) else $error("tx capture wrong");

  property p_rx_align;
    rx_valid_out |-> rx_time_out[pccs_pkg::TAG_W-1:0] == rx_row_out;
  endproperty
  a_rx_align: assert property (p_rx_align) else $error("rx capture misaligned");

  property p_rx_read;
    rd_hit |=> rx_valid_out && rx_time_out == $past(rx_cnt) && rx_row_out == $past(rd_row);
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("row not read on match");

  property p_adj;
    st_r.sst == pccs_pkg::SYNC_ADJ && st_r.txs[pccs_pkg::LT_W-1:0] != st_r.lt
      |=> st_r.sst == pccs_pkg::SYNC_ADJ && st_r.txs != $past(st_r.txs) && sync_busy_out;
  endproperty
  a_adj: assert property (p_adj) else $error("stamp adjust stalled");

  property p_load;
    sync_done_out |-> st_r.rxc == $past(rxs_ld) && st_r.ext == $past(txs_ld[pccs_pkg::CNT_W-1:pccs_pkg::LT_W]);
  endproperty
  a_load: assert property (p_load) else $error("sync load wrong");

  property p_start;
    IS_UNIT && sync_req_in && st_r.sst == pccs_pkg::SYNC_IDLE ##1 1'b1 |-> sync_busy_out || sync_done_out;
  endproperty
  a_start: assert property (p_start) else $error("sync did not start");

  // a terminal never enters the sync sequence
  property p_term_idle;
    !IS_UNIT |-> !sync_busy_out && !sync_done_out;
  endproperty
  a_term_idle: assert property (p_term_idle) else $error("terminal started sync");

  // no read edge means no read-out pulse
  property p_rx_quiet;
    !rd_hit |=> !rx_valid_out;
  endproperty
  a_rx_quiet: assert property (p_rx_quiet) else $error("spurious row read");

  // receive counter steps on each tick while the sync sequencer is idle
  property p_rxc_step;
    eqt_tick_in && st_r.sst == pccs_pkg::SYNC_IDLE |=> st_r.rxc == $past(st_r.rxc) + 1'b1;
  endproperty
  a_rxc_step: assert property (p_rxc_step) else $error("receive counter did not step");

  // misalignment flag stays until an accepted sync request
  property p_err_sticky;
    rx_align_err_out && !(IS_UNIT && sync_req_in && st_r.sst == pccs_pkg::SYNC_IDLE) |=> rx_align_err_out;
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("alignment flag lost");

  // acknowledge is a single pulse
  property p_done_pulse;
    sync_done_out |=> !sync_done_out;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("sync done not a pulse");

  c_sync_done: cover property (sync_done_out);
  c_rx_read: cover property (rx_valid_out);
  c_tx_then_rx: cover property (tx_valid_out ##[1:64] rx_valid_out);

endmodule

// [bench/pccs_peer_model.sv]
// peer terminal model: sends position-tagged headers and counter sync requests
`timescale 1ns/10ps

module pccs_peer_model #(
  parameter logic [47:0] CNT0 = 48'hffff_ffff_fe00, // start value chosen near the wrap
  parameter logic [47:0] RTT  = 48'h0000_0000_0080  // round trip of this link
) (
  // clock, reset and time base
  input  wire logic        core_clk_in,
  input  wire logic        srst_in,
  input  wire logic        eqt_tick_in,
  // commands from the bench
  input  wire logic        send_in,
  input  wire logic [31:0] data_in,
  input  wire logic        sync_in,
  input  wire logic [7:0]  lag_in,
  // towards the unit
  output logic             hdr_out,
  output logic [5:0]       tag_out,
  output logic [31:0]      data_out,
  output logic             sync_out,
  output logic [47:0]      tx_stamp_out,
  output logic [47:0]      rx_stamp_out,
  output logic [31:0]      peer_time_out
);
  logic [47:0] cnt_r;
  logic [47:0] cap_r;
  logic [7:0]  wait_r;
  logic        pend_r;
  logic        fire;

  assign peer_time_out = cnt_r[31:0];
  assign fire          = pend_r && (wait_r == 8'h00);

  // peer counter steps on the shared quantum tick
  always @(posedge core_clk_in) begin
    cnt_r <= srst_in ? CNT0 : cnt_r + {47'h0, eqt_tick_in};
  end

  // released lines show the inverse of their last value, never a stale copy
  always @(negedge core_clk_in) begin
    if (srst_in) begin
      {hdr_out, tag_out, data_out, sync_out, tx_stamp_out, rx_stamp_out} <= '0;
      {cap_r, wait_r, pend_r} <= '0;
    end else begin
      hdr_out      <= send_in;
      tag_out      <= send_in ? cnt_r[5:0] : ~tag_out;
      data_out     <= send_in ? data_in : ~data_out;
      sync_out     <= fire;
      tx_stamp_out <= fire ? cap_r + RTT : ~tx_stamp_out;
      rx_stamp_out <= fire ? cap_r : ~rx_stamp_out;
      // a late request is the slow answer; lag stays far below one second
      if (sync_in) begin
        cap_r  <= cnt_r;
        wait_r <= lag_in;
        pend_r <= 1'b1;
      end else if (fire) begin
        pend_r <= 1'b0;
      end else if (pend_r) begin
        wait_r <= wait_r - 8'h01;
      end
    end
  end
endmodule

// [bench/pon_cipher_clock_sync_tb.sv]
// self-checking bench for the network unit cipher counters
`timescale 1ns/10ps

module pon_cipher_clock_sync_tb;
  localparam logic [47:0] RTT = 48'h0000_0000_0080;
  logic core_clk_in = 1'b0;
  logic srst_in, tick, mload, txh, send, scmd, rxh, sreq, txv, rxv, busy, done, err, ld;
  logic [31:0] mval, sdata, rdata, ptime, lt_o, rxdat, m_lt, seed;
  logic [47:0] tst, rst_s, txc, rxc, txtime, rxtime, m_rx, m_tst, m_rs;
  logic [5:0]  rtag, txtag, rxrow;
  logic [7:0]  lag;
  logic [15:0] m_ext;
  logic [31:0] t_lt;
  logic [47:0] t_txc, t_rxc;
  logic        t_busy, t_done, t_err;
  logic        m_busy, m_done, m_err;
  logic [63:0] filled;
  logic [31:0] rows [64];
  logic [53:0] tx_q [$];
  logic [85:0] rx_q [$];
  int failures = 0;
  int n_compared = 0;

  always #20 core_clk_in = ~core_clk_in;

  pccs_peer_model #(.RTT(RTT)) PEER (.core_clk_in(core_clk_in), .srst_in(srst_in), .eqt_tick_in(tick),
    .send_in(send), .data_in(sdata), .sync_in(scmd), .lag_in(lag), .hdr_out(rxh), .tag_out(rtag),
    .data_out(rdata), .sync_out(sreq), .tx_stamp_out(tst), .rx_stamp_out(rst_s), .peer_time_out(ptime));

  pccs_top #(.IS_UNIT(1'b1)) DUT (.core_clk_in(core_clk_in), .srst_in(srst_in), .eqt_tick_in(tick),
    .mpcp_load_in(mload), .mpcp_load_val_in(mval), .tx_hdr_in(txh), .rx_hdr_in(rxh), .rx_tag_in(rtag),
    .rx_hdr_data_in(rdata), .sync_req_in(sreq), .transmit_sync_stamp_in(tst), .receive_sync_stamp_in(rst_s),
    .mpcp_local_time_out(lt_o), .tx_cipher_count_out(txc), .rx_cipher_count_out(rxc), .tx_valid_out(txv),
    .tx_tag_out(txtag), .tx_time_out(txtime), .rx_valid_out(rxv), .rx_row_out(rxrow),
    .rx_hdr_data_out(rxdat), .rx_time_out(rxtime), .sync_busy_out(busy), .sync_done_out(done),
    .rx_align_err_out(err));

  // terminal role on the same stimulus: one shared counter, sync ignored
  pccs_top #(.IS_UNIT(1'b0)) DUT_TERM (.core_clk_in(core_clk_in), .srst_in(srst_in), .eqt_tick_in(tick),
    .mpcp_load_in(mload), .mpcp_load_val_in(mval), .tx_hdr_in(txh), .rx_hdr_in(rxh), .rx_tag_in(rtag),
    .rx_hdr_data_in(rdata), .sync_req_in(sreq), .transmit_sync_stamp_in(tst), .receive_sync_stamp_in(rst_s),
    .mpcp_local_time_out(t_lt), .tx_cipher_count_out(t_txc), .rx_cipher_count_out(t_rxc), .tx_valid_out(),
    .tx_tag_out(), .tx_time_out(), .rx_valid_out(), .rx_row_out(), .rx_hdr_data_out(), .rx_time_out(),
    .sync_busy_out(t_busy), .sync_done_out(t_done), .rx_align_err_out(t_err));

  // ****************************************************************
  // reference model, notes expected captures in queues
  // ****************************************************************
  always @(posedge core_clk_in) begin
    ld = 1'b0;
    if (srst_in) begin
      {m_lt, m_ext, m_rx, m_busy, m_done, m_err, filled} = '0;
    end else begin
      m_done = 1'b0;
      if (tick && filled[m_rx[5:0]]) begin
        rx_q.push_back({m_rx[5:0], rows[m_rx[5:0]], m_rx});
        filled[m_rx[5:0]] = 1'b0;
      end
      if (txh) tx_q.push_back({m_lt[5:0], m_ext, m_lt});
      if (m_busy && m_tst[31:0] == m_lt) begin
        ld = 1'b1;
        {m_busy, m_done} = 2'b01;
      end else if (m_busy) begin
        m_tst = m_tst + 48'h1 + {47'h0, tick};
        m_rs  = m_rs + 48'h1 + {47'h0, tick};
      end else if (sreq) begin
        {m_busy, m_err, m_tst, m_rs} = {2'b10, tst, rst_s};
      end
      if (rxh) begin
        m_err = m_err | filled[rtag];
        filled[rtag] = 1'b1;
        rows[rtag] = rdata;
      end
      // both unit counters load together, then follow local time
      if (ld) begin
        {m_ext, m_lt} = m_tst + {47'h0, tick};
        m_rx = m_rs + {47'h0, tick};
      end else begin
        if (mload) m_lt = mval;
        else {m_ext, m_lt} = {m_ext, m_lt} + {47'h0, tick};
        m_rx = m_rx + {47'h0, tick};
      end
    end
  end

  task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // ****************************************************************
  // output monitor, compares against the oldest note
  // ****************************************************************
  always @(negedge core_clk_in) begin
    if (!srst_in) begin
      chk("local time", lt_o, m_lt);
      chk("tx counter", txc, {m_ext, m_lt});
      chk("rx counter", rxc, m_rx);
      chk("sync flags", {busy, done, err}, {m_busy, m_done, m_err});
      chk("tx valid", txv, tx_q.size() != 0);
      if (txv && tx_q.size() != 0) chk("tx capture", {txtag, txtime}, tx_q.pop_front());
      chk("rx valid", rxv, rx_q.size() != 0);
      if (rxv && rx_q.size() != 0) chk("rx read", {rxrow, rxdat, rxtime}, rx_q.pop_front());
      chk("terminal time", t_lt, lt_o);
      chk("terminal shared counter", t_rxc, t_txc);
      chk("terminal sync ignored", {t_busy, t_done}, 2'b00);
    end
  end

  task automatic run(input int n);
    repeat (n) begin
      tick <= ($urandom % 4) != 0;
      @(negedge core_clk_in);
    end
  endtask

  // local time loads only on a cycle without a tick
  task automatic load(input logic [31:0] v);
    tick  <= 1'b0;
    mload <= 1'b1;
    mval  <= v;
    @(negedge core_clk_in);
    mload <= 1'b0;
  endtask

  // the bench keys nothing, so no key use precedes the done pulse
  task automatic sync(input logic [7:0] l, input int w);
    scmd <= 1'b1;
    lag  <= l;
    run(1);
    scmd <= 1'b0;
    run(w);
  endtask

  task automatic end_of_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #(40 * 3000);
    failures++;
    end_of_test;
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {tick, mload, mval, txh, send, sdata, scmd, lag} = '0;
    srst_in = 1'b1;
    seed = $urandom(32'haa61);
    repeat (2) @(negedge core_clk_in);
    srst_in <= 1'b0;
    run(5);
    load(32'hffff_fff8);
    run(20);
    txh <= 1'b1;
    run(4);
    txh <= 1'b0;
    run(3);
    load(ptime + RTT[31:0]);
    sync(8'h00, 20);
    sync(8'h19, 45);
    for (int i = 0; i < 6; i++) begin
      send  <= 1'b1;
      sdata <= $urandom;
      run(1);
      send  <= 1'b0;
      run(3);
    end
    // two headers with one tag overwrite an unread row
    tick  <= 1'b0;
    send  <= 1'b1;
    sdata <= $urandom;
    @(negedge core_clk_in);
    sdata <= $urandom;
    @(negedge core_clk_in);
    send  <= 1'b0;
    run(120);
    sync(8'h03, 25);
    run(400);
    end_of_test;
  end
endmodule
